// [design/sbau_alarm_unit.v]
// Spectral band alarm unit: serial register port, band limit store and per-record alarm evaluation.
`timescale 1ns/1ps
`include "sbau_defines.vh"

module sbau_alarm_unit #(
    parameter BIN_W = 8,
    parameter MAG_W = 16
) (
    input wire clock_i,
    input wire reset_i,
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire spi_din_i,
    output wire spi_dout_o,
    output wire spi_dout_oe_o,
    input wire [1:0] sample_rate_option_i,
    input wire record_start_i,
    input wire bin_valid_i,
    input wire [BIN_W-1:0] bin_index_i,
    input wire [MAG_W-1:0] x_magnitude_i,
    input wire [MAG_W-1:0] y_magnitude_i,
    input wire [MAG_W-1:0] z_magnitude_i,
    input wire record_end_i,
    input wire system_meas_valid_i,
    input wire [11:0] temperature_i,
    input wire [11:0] supply_i,
    input wire clear_status_i,
    output wire aux_pin_one_o,
    output wire aux_pin_two_o,
    output wire [2:0] overall_alarm_o
);
    localparam NB = `SBAU_NUM_BANDS;
    localparam NR = `SBAU_NUM_RATES;
    localparam NF = 2 * NB * `SBAU_NUM_AXES;

    reg [BIN_W-1:0] low_mem [0:NB*NR-1];
    reg [BIN_W-1:0] high_mem [0:NB*NR-1];
    reg [6*MAG_W-1:0] level_q;
    reg [15:0] pointer_q;
    reg [15:0] sys_level_q;
    reg [15:0] config_q;
    reg [2:0] status_q;
    reg [NF-1:0] hit_q;
    reg [NF-1:0] flag_q;
    reg [3*MAG_W-1:0] peak_q;
    reg [3*MAG_W-1:0] peak_run_q;
    reg [3*BIN_W-1:0] peak_bin_q;
    reg [3*BIN_W-1:0] peak_bin_run_q;
    reg sys_alarm_q;
    reg sclk_q;
    reg cs_n_q;
    reg [3:0] bit_cnt_q;
    reg [15:0] rx_q;
    reg [15:0] tx_q;
    reg [6:0] rd_addr_q;
    reg out_en_q;
    integer k;

    wire [2:0] band_sel = pointer_q[2:0];
    wire [1:0] rate_sel = pointer_q[9:8];
    wire band_ok = (band_sel != 3'd0) && (band_sel <= 3'd6);
    wire [2:0] band_m1 = band_sel - 3'd1;
    wire [4:0] wr_idx = band_ok ? {band_m1, rate_sel} : 5'd0;
    wire [3:0] delay = config_q[`SBAU_CFG_DELAY_HI:`SBAU_CFG_DELAY_LO];
    wire [3*MAG_W-1:0] mags = {z_magnitude_i, y_magnitude_i, x_magnitude_i};
    wire rise = spi_sclk_i & ~sclk_q;
    wire fall = ~spi_sclk_i & sclk_q;
    wire frame_start = cs_n_q & ~spi_cs_n_i;
    wire [15:0] rx_word = {rx_q[14:0], spi_din_i};
    wire word_done = ~spi_cs_n_i & rise & (bit_cnt_q == 4'd15);
    wire any_warn = |(flag_q & {(NF/2){2'b01}});
    wire any_fault = |(flag_q & {(NF/2){2'b10}});

    // Returns the most critical band: lowest band with a fault, else lowest with a warning.
    function [2:0] critical_band;
        input [11:0] f;
        integer b;
        begin
            critical_band = 3'd0;
            for (b = NB - 1; b >= 0; b = b - 1) begin
                if (f[2*b]) begin
                    critical_band = b[2:0] + 3'd1;
                end
            end
            for (b = NB - 1; b >= 0; b = b - 1) begin
                if (f[2*b+1]) begin
                    critical_band = b[2:0] + 3'd1;
                end
            end
        end
    endfunction

    wire [15:0] x_stat = {flag_q[11:0], 1'b0, critical_band(flag_q[11:0])};
    wire [15:0] y_stat = {flag_q[23:12], 1'b0, critical_band(flag_q[23:12])};
    wire [15:0] z_stat = {flag_q[35:24], 1'b0, critical_band(flag_q[35:24])};

    reg [15:0] rd_data;
    always @* begin
        case ({rd_addr_q[6:1], 1'b0})
            `SBAU_BAND_LOW_BIN: rd_data = {8'h00, low_mem[wr_idx]};
            `SBAU_BAND_HIGH_BIN: rd_data = {8'h00, high_mem[wr_idx]};
            `SBAU_X_WARNING_LEVEL: rd_data = level_q[15:0];
            `SBAU_Y_WARNING_LEVEL: rd_data = level_q[31:16];
            `SBAU_Z_WARNING_LEVEL: rd_data = level_q[47:32];
            `SBAU_X_FAULT_LEVEL: rd_data = level_q[63:48];
            `SBAU_Y_FAULT_LEVEL: rd_data = level_q[79:64];
            `SBAU_Z_FAULT_LEVEL: rd_data = level_q[95:80];
            `SBAU_BAND_SELECT_POINTER: rd_data = pointer_q;
            `SBAU_SYSTEM_ALARM_LEVEL: rd_data = sys_level_q;
            `SBAU_ALARM_CONFIG: rd_data = config_q;
            `SBAU_OVERALL_ALARM_STATUS: rd_data = {13'h0000, status_q};
            `SBAU_X_BAND_ALARM_FLAGS: rd_data = x_stat;
            `SBAU_Y_BAND_ALARM_FLAGS: rd_data = y_stat;
            `SBAU_Z_BAND_ALARM_FLAGS: rd_data = z_stat;
            `SBAU_X_PEAK_MAGNITUDE: rd_data = peak_q[15:0];
            `SBAU_Y_PEAK_MAGNITUDE: rd_data = peak_q[31:16];
            `SBAU_Z_PEAK_MAGNITUDE: rd_data = peak_q[47:32];
            `SBAU_X_PEAK_BIN: rd_data = {8'h00, peak_bin_q[7:0]};
            `SBAU_Y_PEAK_BIN: rd_data = {8'h00, peak_bin_q[15:8]};
            `SBAU_Z_PEAK_BIN: rd_data = {8'h00, peak_bin_q[23:16]};
            default: rd_data = 16'h0000;
        endcase
    end

    // Serial port, clock idle high: input sampled on rising edges, output moved on falling edges.
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_q <= 1'b1;
            cs_n_q <= 1'b1;
            bit_cnt_q <= 4'd0;
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            rd_addr_q <= 7'h00;
            out_en_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk_i;
            cs_n_q <= spi_cs_n_i;
            out_en_q <= ~spi_cs_n_i;
            if (frame_start) begin
                bit_cnt_q <= 4'd0;
                tx_q <= rd_data;
            end else if (~spi_cs_n_i) begin
                if (rise) begin
                    rx_q <= rx_word;
                    bit_cnt_q <= bit_cnt_q + 4'd1;
                end
                if (fall && bit_cnt_q != 4'd0) begin
                    tx_q <= {tx_q[14:0], 1'b0};
                end
            end
            if (word_done && !rx_word[15]) begin
                rd_addr_q <= rx_word[14:8];
            end
        end
    end

    assign spi_dout_o = tx_q[15];
    assign spi_dout_oe_o = out_en_q;

    // Register writes: one byte per word, odd address is the upper byte.
    wire wr = word_done & rx_word[15];
    wire [6:0] wa = {rx_word[14:9], 1'b0};
    wire hi = rx_word[8];
    wire [7:0] wd = rx_word[7:0];
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pointer_q <= `SBAU_POINTER_RESET;
            config_q <= `SBAU_CONFIG_RESET;
            sys_level_q <= 16'h0000;
            level_q <= {(6*MAG_W){1'b0}};
            for (k = 0; k < NB * NR; k = k + 1) begin
                low_mem[k] <= {BIN_W{1'b0}};
                high_mem[k] <= {BIN_W{1'b0}};
            end
        end else if (wr) begin
            case (wa)
                `SBAU_BAND_SELECT_POINTER: begin
                    if (hi) begin
                        pointer_q[15:8] <= wd & 8'h03;
                    end else begin
                        pointer_q[7:0] <= wd & 8'h07;
                    end
                end
                `SBAU_BAND_LOW_BIN: begin
                    if (!hi && band_ok) begin
                        low_mem[wr_idx] <= wd;
                    end
                end
                `SBAU_BAND_HIGH_BIN: begin
                    if (!hi && band_ok) begin
                        high_mem[wr_idx] <= wd;
                    end
                end
                `SBAU_ALARM_CONFIG: begin
                    if (hi) begin
                        config_q[15:8] <= wd & 8'h0f;
                    end else begin
                        config_q[7:0] <= wd;
                    end
                end
                `SBAU_SYSTEM_ALARM_LEVEL: begin
                    if (hi) begin
                        sys_level_q[15:8] <= wd;
                    end else begin
                        sys_level_q[7:0] <= wd;
                    end
                end
                `SBAU_X_WARNING_LEVEL: begin
                    if (hi) begin
                        level_q[15:8] <= wd;
                    end else begin
                        level_q[7:0] <= wd;
                    end
                end
                `SBAU_Y_WARNING_LEVEL: begin
                    if (hi) begin
                        level_q[31:24] <= wd;
                    end else begin
                        level_q[23:16] <= wd;
                    end
                end
                `SBAU_Z_WARNING_LEVEL: begin
                    if (hi) begin
                        level_q[47:40] <= wd;
                    end else begin
                        level_q[39:32] <= wd;
                    end
                end
                `SBAU_X_FAULT_LEVEL: begin
                    if (hi) begin
                        level_q[63:56] <= wd;
                    end else begin
                        level_q[55:48] <= wd;
                    end
                end
                `SBAU_Y_FAULT_LEVEL: begin
                    if (hi) begin
                        level_q[79:72] <= wd;
                    end else begin
                        level_q[71:64] <= wd;
                    end
                end
                `SBAU_Z_FAULT_LEVEL: begin
                    if (hi) begin
                        level_q[95:88] <= wd;
                    end else begin
                        level_q[87:80] <= wd;
                    end
                end
                default: begin
                    // Read-only and unmapped addresses ignore writes.
                end
            endcase
        end
    end

    // In-band test per band using the limits of the rate option in use.
    wire [NB-1:0] in_band;
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : g_band
            localparam [2:0] GB = g;
            wire [4:0] idx = {GB, sample_rate_option_i};
            assign in_band[g] = bin_index_i >= low_mem[idx] && bin_index_i <= high_mem[idx];
        end
        // One evaluator per axis, band and level: index = axis*12 + band*2 + level.
        for (g = 0; g < NF; g = g + 1) begin : g_eval
            localparam A = g / (2 * NB);
            localparam B = (g % (2 * NB)) / 2;
            localparam L = g % 2;
            reg [4:0] cnt_q;
            wire [4:0] cnt_n = (cnt_q == 5'd31) ? cnt_q : cnt_q + 5'd1;
            wire en = config_q[A];
            wire over = mags[A*MAG_W +: MAG_W] > level_q[(L*3+A)*MAG_W +: MAG_W];
            always @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    hit_q[g] <= 1'b0;
                    flag_q[g] <= 1'b0;
                    cnt_q <= 5'd0;
                end else begin
                    if (record_start_i) begin
                        hit_q[g] <= 1'b0;
                    end else if (bin_valid_i && en && in_band[B] && over) begin
                        hit_q[g] <= 1'b1;
                    end
                    if (!en) begin
                        cnt_q <= 5'd0;
                        flag_q[g] <= 1'b0;
                    end else if (record_end_i) begin
                        cnt_q <= hit_q[g] ? cnt_n : 5'd0;
                        flag_q[g] <= hit_q[g] && cnt_n >= {1'b0, delay};
                    end
                end
            end
        end
        // Peak magnitude and its bin among in-band bins, per axis.
        for (g = 0; g < `SBAU_NUM_AXES; g = g + 1) begin : g_peak
            wire [MAG_W-1:0] m = mags[g*MAG_W +: MAG_W];
            always @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    peak_run_q[g*MAG_W +: MAG_W] <= {MAG_W{1'b0}};
                    peak_bin_run_q[g*BIN_W +: BIN_W] <= {BIN_W{1'b0}};
                    peak_q[g*MAG_W +: MAG_W] <= {MAG_W{1'b0}};
                    peak_bin_q[g*BIN_W +: BIN_W] <= {BIN_W{1'b0}};
                end else begin
                    if (record_start_i) begin
                        peak_run_q[g*MAG_W +: MAG_W] <= {MAG_W{1'b0}};
                        peak_bin_run_q[g*BIN_W +: BIN_W] <= {BIN_W{1'b0}};
                    end else if (bin_valid_i && config_q[g] && |in_band &&
                                 m > peak_run_q[g*MAG_W +: MAG_W]) begin
                        peak_run_q[g*MAG_W +: MAG_W] <= m;
                        peak_bin_run_q[g*BIN_W +: BIN_W] <= bin_index_i;
                    end
                    if (record_end_i) begin
                        peak_q[g*MAG_W +: MAG_W] <= peak_run_q[g*MAG_W +: MAG_W];
                        peak_bin_q[g*BIN_W +: BIN_W] <= peak_bin_run_q[g*BIN_W +: BIN_W];
                    end
                end
            end
        end
    endgenerate

    // System alarm: temperature or supply against the low 12 bits of the level.
    wire [11:0] sys_meas = config_q[`SBAU_CFG_TEMP] ? temperature_i : supply_i;
    wire sys_trip = config_q[`SBAU_CFG_POLARITY] ? (sys_meas < sys_level_q[11:0]) :
                    (sys_meas > sys_level_q[11:0]);
    wire [2:0] now_stat = {any_fault, any_warn, sys_alarm_q};

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sys_alarm_q <= 1'b0;
            status_q <= 3'b000;
        end else begin
            if (!config_q[`SBAU_CFG_SYS_EN]) begin
                sys_alarm_q <= 1'b0;
            end else if (system_meas_valid_i) begin
                sys_alarm_q <= sys_trip;
            end
            // Latched flags: a new event in the clear cycle still sets the flag.
            if (config_q[`SBAU_CFG_LATCH]) begin
                status_q <= (clear_status_i ? 3'b000 : status_q) | now_stat;
            end else begin
                status_q <= now_stat;
            end
        end
    end

    assign overall_alarm_o = status_q;
    assign aux_pin_one_o = config_q[`SBAU_CFG_PINS] & status_q[`SBAU_STAT_WARNING];
    assign aux_pin_two_o = config_q[`SBAU_CFG_PINS] & status_q[`SBAU_STAT_FAULT];
endmodule

// [design/sbau_defines.vh]
// Register offsets, field positions, reset values and sizes of the spectral band alarm unit.
`ifndef SBAU_DEFINES_VH
`define SBAU_DEFINES_VH
`define SBAU_BAND_LOW_BIN 7'h20
`define SBAU_BAND_HIGH_BIN 7'h22
`define SBAU_X_WARNING_LEVEL 7'h24
`define SBAU_Y_WARNING_LEVEL 7'h26
`define SBAU_Z_WARNING_LEVEL 7'h28
`define SBAU_X_FAULT_LEVEL 7'h2a
`define SBAU_Y_FAULT_LEVEL 7'h2c
`define SBAU_Z_FAULT_LEVEL 7'h2e
`define SBAU_BAND_SELECT_POINTER 7'h30
`define SBAU_SYSTEM_ALARM_LEVEL 7'h32
`define SBAU_ALARM_CONFIG 7'h34
`define SBAU_OVERALL_ALARM_STATUS 7'h3c
`define SBAU_X_BAND_ALARM_FLAGS 7'h40
`define SBAU_Y_BAND_ALARM_FLAGS 7'h42
`define SBAU_Z_BAND_ALARM_FLAGS 7'h44
`define SBAU_X_PEAK_MAGNITUDE 7'h46
`define SBAU_Y_PEAK_MAGNITUDE 7'h48
`define SBAU_Z_PEAK_MAGNITUDE 7'h4a
`define SBAU_X_PEAK_BIN 7'h70
`define SBAU_Y_PEAK_BIN 7'h72
`define SBAU_Z_PEAK_BIN 7'h74
`define SBAU_POINTER_RESET 16'h0000
`define SBAU_CONFIG_RESET 16'h0080
`define SBAU_POINTER_MASK 16'h0307
`define SBAU_CONFIG_MASK 16'h0fff
`define SBAU_BIN_MASK 16'h00ff
`define SBAU_CFG_DELAY_HI 11
`define SBAU_CFG_DELAY_LO 8
`define SBAU_CFG_LATCH 7
`define SBAU_CFG_PINS 6
`define SBAU_CFG_POLARITY 5
`define SBAU_CFG_TEMP 4
`define SBAU_CFG_SYS_EN 3
`define SBAU_STAT_SYSTEM 0
`define SBAU_STAT_WARNING 1
`define SBAU_STAT_FAULT 2
`define SBAU_NUM_BANDS 6
`define SBAU_NUM_RATES 4
`define SBAU_NUM_AXES 3
`define SBAU_WORD_BITS 16
`endif

// [testbench/sbau_alarm_sva.sv]
// Concurrent checks on the ports of the spectral band alarm unit.
`timescale 1ns/1ps
module sbau_alarm_sva (
    input wire clock_i,
    input wire reset_i,
    input wire spi_cs_n_i,
    input wire spi_dout_oe_o,
    input wire record_end_i,
    input wire system_meas_valid_i,
    input wire aux_pin_one_o,
    input wire aux_pin_two_o,
    input wire [2:0] overall_alarm_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_cs_fall;
        $fell(spi_cs_n_i) ##1 !spi_cs_n_i;
    endsequence
    sequence s_cs_rise;
        $rose(spi_cs_n_i) ##1 spi_cs_n_i;
    endsequence
    oe_open_a: assert property (s_cs_fall |-> spi_dout_oe_o)
        else $error("output enable not raised in frame");
    oe_close_a: assert property (s_cs_rise |-> !spi_dout_oe_o)
        else $error("output enable not dropped after frame");
    aux_warn_a: assert property (aux_pin_one_o |-> overall_alarm_o[1])
        else $error("aux pin one high without warning");
    aux_fault_a: assert property (aux_pin_two_o |-> overall_alarm_o[2])
        else $error("aux pin two high without fault");
    warn_rise_a: assert property ($rose(overall_alarm_o[1]) |->
        $past(record_end_i, 1) || $past(record_end_i, 2) || $past(record_end_i, 3))
        else $error("warning raised without record end");
    fault_rise_a: assert property ($rose(overall_alarm_o[2]) |->
        $past(record_end_i, 1) || $past(record_end_i, 2) || $past(record_end_i, 3))
        else $error("fault raised without record end");
    sys_rise_a: assert property ($rose(overall_alarm_o[0]) |->
        $past(system_meas_valid_i, 1) || $past(system_meas_valid_i, 2) || $past(system_meas_valid_i, 3))
        else $error("system alarm raised without measurement");
    reset_clean_a: assert property ($fell(reset_i) |->
        overall_alarm_o == 3'b000 && !aux_pin_one_o && !aux_pin_two_o && !spi_dout_oe_o)
        else $error("outputs not clear after reset");
endmodule

bind sbau_alarm_unit sbau_alarm_sva u_sva (.clock_i(clock_i), .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_dout_oe_o(spi_dout_oe_o), .record_end_i(record_end_i), .system_meas_valid_i(system_meas_valid_i),
    .aux_pin_one_o(aux_pin_one_o), .aux_pin_two_o(aux_pin_two_o), .overall_alarm_o(overall_alarm_o));

// [testbench/sbau_host_model.sv]
// Host model: serial master that writes and reads the alarm unit registers.
`timescale 1ns/1ps
module sbau_host_model (
    input wire clock_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire dout_i
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // Each serial clock phase lasts four system clocks; the released data line shows the inverse value.
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge clock_i) cs_n_o = 1'b0;
        repeat (4) @(negedge clock_i);
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            din_o = w[i];
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b1;
            r[i] = dout_i;
            repeat (4) @(negedge clock_i);
        end
        cs_n_o = 1'b1;
        din_o = ~din_o;
        repeat (4) @(negedge clock_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        xfer({1'b1, a, d}, r);
    endtask
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a | 7'h01, d[15:8]);
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] r);
        xfer({1'b0, a, 8'h00}, r);
        xfer(16'h0000, r);
    endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the spectral band alarm unit.
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] WARN = 16'h0064;
    localparam logic [15:0] FAULT = 16'h00c8;
    localparam int DELAY = 2;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic sclk, cs_n, din, dout, aux1, aux2, wflag, fflag;
    logic rec_start = 1'b0;
    logic bin_valid = 1'b0;
    logic rec_end = 1'b0;
    logic meas_valid = 1'b0;
    logic clr = 1'b0;
    logic [7:0] bin_idx = 8'h00;
    logic [15:0] mag = 16'h0000;
    logic [11:0] temp = 12'h000;
    logic [11:0] sv;
    logic sys_hit;
    logic [1:0] rate = 2'b00;
    logic [2:0] overall;
    logic [15:0] rdata;
    logic [7:0] lim [18];
    int n_errors = 0;
    int checks = 0;
    int wcnt = 0;
    int fcnt = 0;
    int mags [5] = '{150, 150, 250, 250, 50};
    sbau_alarm_unit dut (.clock_i(clock_i), .reset_i(reset_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_o(), .sample_rate_option_i(rate),
        .record_start_i(rec_start), .bin_valid_i(bin_valid), .bin_index_i(bin_idx), .x_magnitude_i(mag),
        .y_magnitude_i(mag), .z_magnitude_i(mag), .record_end_i(rec_end), .system_meas_valid_i(meas_valid),
        .temperature_i(temp), .supply_i(12'h050), .clear_status_i(clr), .aux_pin_one_o(aux1),
        .aux_pin_two_o(aux2), .overall_alarm_o(overall));
    sbau_host_model host (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
    always #4 clock_i = ~clock_i;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic run_rec(input logic [15:0] m, input logic inb);
        @(negedge clock_i) rec_start = 1'b1;
        @(negedge clock_i);
        rec_start = 1'b0;
        bin_valid = 1'b1;
        bin_idx = 8'h0f;
        mag = m;
        @(negedge clock_i);
        bin_idx = 8'h1e;
        mag = 16'h01f4;
        @(negedge clock_i);
        bin_valid = 1'b0;
        rec_end = 1'b1;
        @(negedge clock_i) rec_end = 1'b0;
        repeat (4) @(negedge clock_i);
        wcnt = (inb && m > WARN) ? wcnt + 1 : 0;
        fcnt = (inb && m > FAULT) ? fcnt + 1 : 0;
        wflag = inb && (m > WARN) && wcnt >= DELAY;
        fflag = inb && (m > FAULT) && fcnt >= DELAY;
        check("overall flags", {14'h0000, overall[2:1]}, {14'h0000, fflag, wflag});
        check("aux pins", {14'h0000, aux2, aux1}, {14'h0000, fflag, wflag});
        host.rd(7'h40, rdata);
        check("x band flags", rdata, {10'h000, fflag, wflag, 3'b000, fflag | wflag});
        host.rd(7'h46, rdata);
        check("x peak", rdata, inb ? m : 16'h0000);
        host.rd(7'h70, rdata);
        check("x peak bin", rdata, inb ? 16'h000f : 16'h0000);
    endtask
    task automatic meas(input logic [11:0] t);
        @(negedge clock_i);
        meas_valid = 1'b1;
        temp = t;
        @(negedge clock_i) meas_valid = 1'b0;
        repeat (4) @(negedge clock_i);
    endtask
    initial begin
        repeat (100000) @(posedge clock_i);
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h0000_f0bb));
        repeat (12) @(negedge clock_i);
        reset_i = 1'b0;
        check("overall at reset", {13'h0000, overall}, 16'h0000);
        host.rd(7'h30, rdata);
        check("pointer reset", rdata, 16'h0000);
        host.rd(7'h20, rdata);
        check("low bin reset", rdata, 16'h0000);
        host.rd(7'h34, rdata);
        check("config reset", rdata, 16'h0080);
        host.wr(7'h30, 8'hfd);
        host.wr(7'h31, 8'hfe);
        host.rd(7'h30, rdata);
        check("pointer fields", rdata, 16'h0205);
        $display("Test reset and pointer done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 18; i++) begin
                host.wr16(7'h30, {6'h00, 2'(i / 6 + 1), 5'h00, 3'(i % 6 + 1)});
                if (p == 0) begin
                    lim[i] = 8'($urandom);
                    host.wr16(7'h20, {~lim[i], lim[i]});
                end else begin
                    host.rd(7'h20, rdata);
                    check("band low bin", rdata, {8'h00, lim[i]});
                end
            end
        end
        $display("Test band limits done");
        host.wr16(7'h30, 16'h0001);
        host.wr16(7'h20, 16'h000a);
        host.wr16(7'h22, 16'h0014);
        host.wr16(7'h24, WARN);
        host.wr16(7'h2a, FAULT);
        host.wr16(7'h34, 16'h0241);
        foreach (mags[k]) run_rec(16'(mags[k]), 1'b1);
        @(negedge clock_i) rate = 2'b01;
        run_rec(16'h00fa, 1'b0);
        $display("Test band alarm done");
        host.wr16(7'h32, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            host.wr16(7'h34, 16'h0008 | 16'(i << 4));
            meas(12'h200);
            sv = i[0] ? 12'h200 : 12'h050;
            sys_hit = i[1] ? sv < 12'h100 : sv > 12'h100;
            check("system alarm", {15'h0000, overall[0]}, {15'h0000, sys_hit});
        end
        host.wr16(7'h34, 16'h0010);
        meas(12'h200);
        check("system disabled", {15'h0000, overall[0]}, 16'h0000);
        host.wr16(7'h34, 16'h0098);
        meas(12'h200);
        meas(12'h010);
        check("latched alarm", {15'h0000, overall[0]}, 16'h0001);
        @(negedge clock_i) clr = 1'b1;
        @(negedge clock_i) clr = 1'b0;
        repeat (3) @(negedge clock_i);
        check("cleared alarm", {15'h0000, overall[0]}, 16'h0000);
        $display("Test system alarm done");
        stop_test();
    end
endmodule
